// ===== logic/lhw_dev.sv
`timescale 1ns/1ps
module lhw_dev #(
    parameter int CLR_US = 1600
) (
    // Internal oscillator clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Serial link; the clock line clocks the receiver.
    lhw_if.dev lk,
    // Parallel read port.
    input wire logic par_rd,
    input wire logic par_rs,
    output logic [7:0] par_rdata,
    // Device state.
    output logic bus_width_select,
    output logic op_in_progress_flag,
    output logic [6:0] ram_pointer,
    output lhw_pkg::lhw_ram_t ram_sel,
    output logic [7:0] instruction_holding_reg,
    output logic [7:0] data_holding_reg
);
    import lhw_pkg::*;

    localparam int CLR_CYC = CLR_US * SYS_MHZ;

    // Link domain.
    logic st_tgl_q;
    logic sp_tgl_q;
    logic st_ack_q;
    logic sp_ack_q;
    lhw_slv_t sl_q;
    logic [3:0] bit_q;
    logic [6:0] sh_q;
    logic co_q;
    logic rs_q;
    logic ack_q;
    logic sda_oe_q;
    logic wtgl_q;
    logic [8:0] word_q;
    logic [7:0] rx_byte;
    logic st_seen;
    logic sp_seen;

    // System domain.
    logic [2:0] wsync_q;
    logic wr_ev;
    logic acc_cmd;
    logic acc_dat;
    logic [7:0] wb;
    logic [15:0] busy_q;
    logic [7:0] clr_q;
    logic [6:0] ptr_q;
    logic [6:0] ptr_nxt;
    lhw_ram_t sel_q;
    logic inc_q;
    logic is_q;
    logic bw_q;
    logic [7:0] ir_q;
    logic [7:0] dr_q;
    logic [7:0] par_q;
    logic [7:0] rd_byte;
    logic [7:0] text_ram [0:TEXT_DEPTH-1];
    logic [7:0] glyph_ram [0:GLYPH_DEPTH-1];
    logic [7:0] icon_ram [0:ICON_DEPTH-1];

    function automatic logic [6:0] step(input logic [6:0] p, input logic up);
        step = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
    endfunction : step

    // Start and stop are the only events clocked by the data line. Each is a
    // toggle that the receiver compares at its next clock rise, so no signal
    // is written from two edges.
    always_ff @(negedge lk.sda or negedge rst_b) begin
        if (!rst_b) begin
            st_tgl_q <= 1'b0;
        end else if (lk.scl) begin
            st_tgl_q <= ~st_tgl_q;
        end
    end

    always_ff @(posedge lk.sda or negedge rst_b) begin
        if (!rst_b) begin
            sp_tgl_q <= 1'b0;
        end else if (lk.scl) begin
            sp_tgl_q <= ~sp_tgl_q;
        end
    end

    assign st_seen = st_tgl_q ^ st_ack_q;
    assign sp_seen = sp_tgl_q ^ sp_ack_q;
    assign rx_byte = {sh_q, lk.sda};

    always_ff @(posedge lk.scl or negedge rst_b) begin
        if (!rst_b) begin
            st_ack_q <= 1'b0;
            sp_ack_q <= 1'b0;
        end else begin
            st_ack_q <= st_tgl_q;
            sp_ack_q <= sp_tgl_q;
        end
    end

    // Receiver: one bit per rise of the clock, ninth clock is the acknowledge.
    always_ff @(posedge lk.scl or negedge rst_b) begin
        if (!rst_b) begin
            sl_q <= LHW_SL_SKIP;
            bit_q <= 4'h0;
            sh_q <= 7'h00;
            ack_q <= 1'b0;
        end else if (st_seen) begin
            sl_q <= LHW_SL_ADDR;
            sh_q <= {6'h00, lk.sda};
            bit_q <= 4'h1;
            ack_q <= 1'b0;
        end else if (sp_seen) begin
            sl_q <= LHW_SL_SKIP;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
        end else begin
            sh_q <= rx_byte[6:0];
            bit_q <= 4'(bit_q + 4'h1);
            if (bit_q == 4'h7) begin
                ack_q <= 1'b0;
                case (sl_q)
                    LHW_SL_ADDR: begin
                        if (rx_byte[7:1] == SLAVE_ADDR && !rx_byte[0]) begin
                            sl_q <= LHW_SL_CTRL;
                            ack_q <= 1'b1;
                        end else begin
                            sl_q <= LHW_SL_SKIP;
                        end
                    end
                    LHW_SL_CTRL: begin
                        sl_q <= LHW_SL_DATA;
                        ack_q <= 1'b1;
                    end
                    LHW_SL_DATA: begin
                        sl_q <= co_q ? LHW_SL_CTRL : LHW_SL_DATA;
                        ack_q <= 1'b1;
                    end
                    default: begin
                        sl_q <= LHW_SL_SKIP;
                    end
                endcase
            end
        end
    end

    // Flags of the control byte and the hand-over word for the system side.
    always_ff @(posedge lk.scl or negedge rst_b) begin
        if (!rst_b) begin
            co_q <= 1'b0;
            rs_q <= 1'b0;
            word_q <= 9'h000;
            wtgl_q <= 1'b0;
        end else if (!st_seen && !sp_seen && bit_q == 4'h7) begin
            if (sl_q == LHW_SL_CTRL) begin
                co_q <= rx_byte[CO_BIT];
                rs_q <= rx_byte[RS_BIT];
            end else if (sl_q == LHW_SL_DATA) begin
                word_q <= {rs_q, rx_byte};
                wtgl_q <= ~wtgl_q;
            end
        end
    end

    // The acknowledge is held from the fall after bit eight to the fall after
    // the ninth clock, so it is stable through the whole high phase.
    always_ff @(negedge lk.scl or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= ack_q && bit_q == 4'h8;
        end
    end

    assign lk.dev_sda_o = 1'b0;
    assign lk.dev_sda_oe = sda_oe_q;

    // The word is written nine link clocks before it can change again, so it
    // is stable when the synchronised toggle reaches this side.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wsync_q <= 3'h0;
        end else begin
            wsync_q <= {wsync_q[1:0], wtgl_q};
        end
    end

    assign wr_ev = wsync_q[1] ^ wsync_q[2];
    assign wb = word_q[7:0];
    assign acc_cmd = wr_ev && !word_q[8] && busy_q == 16'h0000;
    assign acc_dat = wr_ev && word_q[8] && clr_q == 8'h00;
    assign ptr_nxt = step(ptr_q, inc_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 16'h0000;
        end else if (acc_cmd) begin
            busy_q <= (wb == CLEAR_CMD) ? 16'(CLR_CYC) : 16'(BUSY_CYC);
        end else if (busy_q != 16'h0000) begin
            busy_q <= 16'(busy_q - 16'h0001);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_q <= 8'h00;
        end else if (acc_cmd && wb == CLEAR_CMD) begin
            clr_q <= CLEAR_LEN;
        end else if (clr_q != 8'h00) begin
            clr_q <= 8'(clr_q - 8'h01);
        end
    end

    // Instruction decode, pointer and holding registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= 7'h00;
            sel_q <= LHW_TEXT;
            inc_q <= 1'b1;
            is_q <= 1'b0;
            bw_q <= 1'b1;
            ir_q <= 8'h00;
            dr_q <= 8'h00;
        end else if (acc_cmd) begin
            ir_q <= wb;
            if (wb[7]) begin
                sel_q <= LHW_TEXT;
                ptr_q <= wb[6:0];
            end else if (wb[7:6] == 2'b01 && !is_q) begin
                sel_q <= LHW_GLYPH;
                ptr_q <= {1'b0, wb[5:0]};
            end else if (wb[7:4] == 4'b0100 && is_q) begin
                sel_q <= LHW_ICON;
                ptr_q <= {3'h0, wb[3:0]};
            end else if (wb[7:5] == 3'b001) begin
                bw_q <= wb[4];
                is_q <= wb[0];
            end else if (wb[7:2] == 6'b000001) begin
                inc_q <= wb[1];
            end else if (wb[7:1] == 7'b0000001) begin
                ptr_q <= 7'h00;
            end else if (wb == CLEAR_CMD) begin
                ptr_q <= 7'h00;
                inc_q <= 1'b1;
                sel_q <= LHW_TEXT;
            end
        end else if (acc_dat) begin
            dr_q <= wb;
            ptr_q <= ptr_nxt;
        end else if (par_rd && par_rs) begin
            dr_q <= rd_byte;
            ptr_q <= ptr_nxt;
        end
    end

    always_comb begin
        case (sel_q)
            LHW_GLYPH: rd_byte = glyph_ram[ptr_nxt[5:0]];
            LHW_ICON: rd_byte = icon_ram[ptr_nxt[3:0]];
            default: rd_byte = text_ram[ptr_nxt];
        endcase
    end

    // RAM write port; a clear in progress owns the text RAM.
    always_ff @(posedge sys_clk) begin
        if (clr_q != 8'h00) begin
            text_ram[7'(clr_q - 8'h01)] <= CLEAR_CHAR;
        end else if (acc_dat) begin
            case (sel_q)
                LHW_GLYPH: glyph_ram[ptr_q[5:0]] <= wb;
                LHW_ICON: icon_ram[ptr_q[3:0]] <= wb;
                default: text_ram[ptr_q] <= wb;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            par_q <= 8'h00;
        end else if (par_rd) begin
            par_q <= par_rs ? dr_q : {busy_q != 16'h0000, ptr_q};
        end
    end

    assign par_rdata = par_q;
    assign bus_width_select = bw_q;
    assign op_in_progress_flag = busy_q != 16'h0000;
    assign ram_pointer = ptr_q;
    assign ram_sel = sel_q;
    assign instruction_holding_reg = ir_q;
    assign data_holding_reg = dr_q;
endmodule : lhw_dev

// ===== logic/lhw_pkg.sv
// Function
// - Answer only to fixed address 0111110.
// - Master always sends direction bit as write.
// - Device drives only acknowledge bits onto data.
// - Acknowledge never signals busy.
// - One bit per clock; data changes while low.
// - Data rise with clock high is stop; fall is start.
// - Master starts on idle bus, ends with stop.
// - Foreign address: no acknowledge, no state change.
// - Acknowledge every byte, data low on ninth clock.
// - Command word is control byte plus data byte.
// - Cleared continuation flag makes rest data bytes.
// - Register select one writes RAM, pointer advances.
// - Register select zero decodes an instruction.
// - Eight-bit instruction and data holding registers.
// - Data byte goes to last selected RAM.
// - Parallel bus width set by width bit.
// - Parallel read returns data, preloads next address.
// - Host 3 V start-up instruction sequence.
// - Host 5 V start-up uses other three values.
// - Pointer steps by one per direction setting.
// - Busy flag high blocks next instruction.
package lhw_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h3e;
    localparam int CO_BIT = 7;
    localparam int RS_BIT = 6;
    localparam int SYS_MHZ = 20;
    localparam int BUSY_US = 30;
    localparam int BUSY_CYC = BUSY_US * SYS_MHZ;
    localparam int SCL_QTR_CYC = 4;
    localparam int TEXT_DEPTH = 128;
    localparam int GLYPH_DEPTH = 64;
    localparam int ICON_DEPTH = 16;
    localparam logic [7:0] CLEAR_CMD = 8'h01;
    localparam logic [7:0] CLEAR_CHAR = 8'h20;
    localparam logic [7:0] CLEAR_LEN = 8'h80;
    localparam logic [3:0] INIT_LEN = 4'h8;

    typedef enum logic [1:0] {LHW_TEXT, LHW_GLYPH, LHW_ICON} lhw_ram_t;
    typedef enum logic [1:0] {LHW_SL_ADDR, LHW_SL_CTRL, LHW_SL_DATA, LHW_SL_SKIP} lhw_slv_t;
    typedef enum logic [2:0] {LHW_H_IDLE, LHW_H_START, LHW_H_BIT, LHW_H_STOP, LHW_H_WAIT} lhw_hst_t;

    // Start-up instruction list; three entries differ with the supply.
    function automatic logic [7:0] lhw_init_byte(input logic [3:0] idx, input logic volt5);
        case (idx)
            4'h0: lhw_init_byte = 8'h38;
            4'h1: lhw_init_byte = 8'h39;
            4'h2: lhw_init_byte = 8'h14;
            4'h3: lhw_init_byte = volt5 ? 8'h79 : 8'h74;
            4'h4: lhw_init_byte = volt5 ? 8'h50 : 8'h54;
            4'h5: lhw_init_byte = volt5 ? 8'h6c : 8'h6f;
            4'h6: lhw_init_byte = 8'h0c;
            default: lhw_init_byte = 8'h01;
        endcase
    endfunction : lhw_init_byte
endpackage : lhw_pkg

// ===== logic/lhw_if.sv
`timescale 1ns/1ps
interface lhw_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: low wins whenever any party drives low.
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
        input scl, sda
    );
    modport dev (
        output dev_sda_o, dev_sda_oe,
        input scl, sda
    );
endinterface : lhw_if

// ===== logic/lhw_host.sv
`timescale 1ns/1ps
module lhw_host #(
    parameter int WAIT_US = 1600
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Serial link; this end makes the clock.
    lhw_if.host lk,
    // Start-up selection.
    input wire logic volt5_sel,
    // Command port.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_rs,
    input wire logic [7:0] cmd_data,
    // Status.
    output logic init_done,
    output logic nack,
    output logic xfer_busy
);
    import lhw_pkg::*;

    localparam int WAIT_CYC = WAIT_US * SYS_MHZ;

    lhw_hst_t st_q;
    logic [1:0] sda_s_q;
    logic [2:0] qcnt_q;
    logic tick;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    logic rs_q;
    logic [7:0] dat_q;
    logic scl_q;
    logic sdal_q;
    logic [3:0] init_q;
    logic nack_q;
    logic [15:0] wait_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_s_q <= 2'b11;
        end else begin
            sda_s_q <= {sda_s_q[0], lk.sda};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            qcnt_q <= 3'h0;
        end else begin
            qcnt_q <= tick ? 3'h0 : 3'(qcnt_q + 3'h1);
        end
    end

    assign tick = qcnt_q == 3'(SCL_QTR_CYC - 1);

    // Each transfer carries one command word: address, control byte with the
    // continuation flag cleared, data byte, then stop.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= LHW_H_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            sh_q <= 8'h00;
            rs_q <= 1'b0;
            dat_q <= 8'h00;
            scl_q <= 1'b1;
            sdal_q <= 1'b1;
            init_q <= 4'h0;
            nack_q <= 1'b0;
            wait_q <= 16'h0000;
        end else begin
            case (st_q)
                LHW_H_IDLE: begin
                    ph_q <= 2'h0;
                    if (init_q != INIT_LEN || cmd_valid) begin
                        rs_q <= (init_q == INIT_LEN) && cmd_rs;
                        dat_q <= (init_q == INIT_LEN) ? cmd_data
                                                      : lhw_init_byte(init_q, volt5_sel);
                        nack_q <= 1'b0;
                        st_q <= LHW_H_START;
                    end
                end
                LHW_H_START: if (tick) begin
                    ph_q <= 2'(ph_q + 2'h1);
                    if (ph_q == 2'h0) begin
                        sdal_q <= 1'b0;
                    end else begin
                        scl_q <= 1'b0;
                        sh_q <= {SLAVE_ADDR, 1'b0};
                        bit_q <= 4'h0;
                        byte_q <= 2'h0;
                        ph_q <= 2'h0;
                        st_q <= LHW_H_BIT;
                    end
                end
                LHW_H_BIT: if (tick) begin
                    ph_q <= 2'(ph_q + 2'h1);
                    case (ph_q)
                        2'h0: sdal_q <= (bit_q == 4'h8) || sh_q[7];
                        2'h1: scl_q <= 1'b1;
                        2'h2: if (bit_q == 4'h8 && sda_s_q[1]) nack_q <= 1'b1;
                        default: begin
                            scl_q <= 1'b0;
                            if (bit_q != 4'h8) begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= 4'(bit_q + 4'h1);
                            end else begin
                                bit_q <= 4'h0;
                                byte_q <= 2'(byte_q + 2'h1);
                                sh_q <= (byte_q == 2'h0) ? {1'b0, rs_q, 6'h00} : dat_q;
                                if (byte_q == 2'h2) begin
                                    st_q <= LHW_H_STOP;
                                end
                            end
                        end
                    endcase
                end
                LHW_H_STOP: if (tick) begin
                    ph_q <= 2'(ph_q + 2'h1);
                    case (ph_q)
                        2'h0: sdal_q <= 1'b0;
                        2'h1: scl_q <= 1'b1;
                        2'h2: sdal_q <= 1'b1;
                        default: begin
                            wait_q <= 16'(WAIT_CYC);
                            if (init_q != INIT_LEN) begin
                                init_q <= 4'(init_q + 4'h1);
                            end
                            st_q <= LHW_H_WAIT;
                        end
                    endcase
                end
                LHW_H_WAIT: begin
                    if (wait_q == 16'h0000) begin
                        st_q <= LHW_H_IDLE;
                    end else begin
                        wait_q <= 16'(wait_q - 16'h0001);
                    end
                end
                default: st_q <= LHW_H_IDLE;
            endcase
        end
    end

    assign lk.host_scl_o = 1'b0;
    assign lk.host_scl_oe = !scl_q;
    assign lk.host_sda_o = 1'b0;
    assign lk.host_sda_oe = !sdal_q;
    assign cmd_ready = st_q == LHW_H_IDLE && init_q == INIT_LEN;
    assign init_done = init_q == INIT_LEN;
    assign nack = nack_q;
    assign xfer_busy = st_q != LHW_H_IDLE;
endmodule : lhw_host

// ===== dv/lhw_props.sv
`timescale 1ns/1ps
module lhw_props (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Link drivers and resolved wires.
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    import lhw_pkg::*;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_q;
    logic [3:0] byte_q;
    logic [7:0] sh_q;
    logic rise;
    logic start;
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Bit position within the byte; the ninth rise is the acknowledge slot.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_q <= 4'h0;
        end else if (start) begin
            bit_q <= 4'h0;
        end else if (rise) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_q <= 4'h0;
        end else if (start) begin
            byte_q <= 4'h0;
        end else if (rise && bit_q == 4'h8 && byte_q != 4'hf) begin
            byte_q <= byte_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= 8'h00;
        end else if (rise && bit_q != 4'h8) begin
            sh_q <= {sh_q[6:0], sda};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence ack_hold;
        dev_sda_oe [*8] ##1 dev_sda_oe [*7];
    endsequence
    sequence bus_idle;
        (sda && scl) [*8];
    endsequence
    chk_addr_fixed: assert property (rise && bit_q == 4'h8 && byte_q == 4'h0 |->
        sh_q == {SLAVE_ADDR, 1'b0}) else $error("address byte differs");
    chk_ctrl_byte: assert property (rise && bit_q == 4'h8 && byte_q == 4'h1 |->
        !sh_q[CO_BIT] && sh_q[5:0] == 6'h00) else $error("control byte malformed");
    chk_ack_ninth: assert property (rise && bit_q == 4'h8 |-> !sda && dev_sda_oe)
        else $error("no acknowledge on ninth clock");
    chk_ack_window: assert property (dev_sda_oe |->
        bit_q == 4'h8 || (bit_q == 4'h0 && scl)) else $error("device drives outside ack");
    chk_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data changed with clock high");
    chk_ack_one_clk: assert property ($rose(dev_sda_oe) |-> ack_hold ##[1:2] !dev_sda_oe)
        else $error("acknowledge length wrong");
    chk_start_scl: assert property ($rose(host_sda_oe) && scl |-> ##[1:8] host_scl_oe)
        else $error("clock not lowered after start");
    chk_stop_idle: assert property ($fell(host_sda_oe) && scl |=> bus_idle)
        else $error("bus not idle after stop");
endmodule : lhw_props

// ===== dv/lcd_host_write_interface_tb.sv
`timescale 1ns/1ps
module lcd_host_write_interface_tb;
    import lhw_pkg::*;
    localparam int TMO_CYC = 60000;
    logic sys_clk, rst_b, volt5_sel, cmd_valid, cmd_rs, par_rd, par_rs;
    logic [7:0] cmd_data, par_rdata, ir, dr, d2_ir, d2_dr;
    logic cmd_ready, init_done, nack, xfer_busy, bus_width_select, op_in_progress_flag, d2_busy;
    logic [6:0] ram_pointer, d2_ptr;
    lhw_ram_t ram_sel;
    int error_cnt, checked, cyc;
    logic [7:0] ir_log[$];
    logic [7:0] exp3[8] = '{8'h38, 8'h39, 8'h14, 8'h74, 8'h54, 8'h6f, 8'h0c, 8'h01};
    logic [7:0] exp5[8] = '{8'h38, 8'h39, 8'h14, 8'h79, 8'h50, 8'h6c, 8'h0c, 8'h01};
    logic [7:0] fr[10] = '{8'h7c, 8'h80, 8'h06, 8'h80, 8'h85, 8'hc0, 8'h55, 8'h40, 8'h66, 8'hc0};
    lhw_if lk1 ();
    lhw_if lk2 ();
    lhw_host #(.WAIT_US(40)) lhw_host_i (.sys_clk(sys_clk), .rst_b(rst_b), .lk(lk1),
        .volt5_sel(volt5_sel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rs(cmd_rs),
        .cmd_data(cmd_data), .init_done(init_done), .nack(nack), .xfer_busy(xfer_busy));
    lhw_dev #(.CLR_US(10)) lhw_dev_i (.sys_clk(sys_clk), .rst_b(rst_b), .lk(lk1),
        .par_rd(par_rd), .par_rs(par_rs), .par_rdata(par_rdata),
        .bus_width_select(bus_width_select), .op_in_progress_flag(op_in_progress_flag),
        .ram_pointer(ram_pointer), .ram_sel(ram_sel), .instruction_holding_reg(ir),
        .data_holding_reg(dr));
    // The second device faces the bench driver, which breaks the master's rules on purpose.
    lhw_dev #(.CLR_US(10)) lhw_dev_i2 (.sys_clk(sys_clk), .rst_b(rst_b), .lk(lk2),
        .par_rd(1'b0), .par_rs(1'b0), .par_rdata(), .bus_width_select(),
        .op_in_progress_flag(d2_busy), .ram_pointer(d2_ptr), .ram_sel(),
        .instruction_holding_reg(d2_ir), .data_holding_reg(d2_dr));
    lhw_props lhw_props_i (.sys_clk(sys_clk), .rst_b(rst_b), .host_scl_oe(lk1.host_scl_oe),
        .host_sda_oe(lk1.host_sda_oe), .dev_sda_oe(lk1.dev_sda_oe), .scl(lk1.scl),
        .sda(lk1.sda));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == TMO_CYC) begin
            error_cnt++;
            stop_test();
        end
    end
    always @(ir) begin
        if (rst_b === 1'b1) ir_log.push_back(ir);
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_ready
    task automatic send_cmd(input logic rs, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_rs = rs;
        cmd_data = d;
        wait_ready();
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        chk(8'(xfer_busy), 8'h01);
        wait_ready();
        chk(8'(nack), 8'h00);
        chk(8'(xfer_busy), 8'h00);
    endtask : send_cmd
    task automatic par_read(input logic rs);
        @(negedge sys_clk);
        par_rs = rs;
        par_rd = 1'b1;
        @(negedge sys_clk);
        par_rd = 1'b0;
        @(negedge sys_clk);
    endtask : par_read
    task automatic t_startup(input logic v5);
        @(negedge sys_clk);
        rst_b = 1'b0;
        volt5_sel = v5;
        repeat (3) @(negedge sys_clk);
        chk(8'(bus_width_select), 8'h01);
        chk(8'(ram_sel), 8'(LHW_TEXT));
        ir_log.delete();
        rst_b = 1'b1;
        @(negedge sys_clk);
        wait_ready();
        chk(8'(init_done), 8'h01);
        chk(8'(ir_log.size()), 8'h08);
        for (int i = 0; i < 8 && i < ir_log.size(); i++) begin
            chk(ir_log[i], v5 ? exp5[i] : exp3[i]);
        end
        chk(8'(ram_pointer), 8'h00);
        chk(8'(op_in_progress_flag), 8'h00);
    endtask : t_startup
    task automatic t_ram_paths();
        send_cmd(1'b0, 8'h06);
        send_cmd(1'b0, 8'h90);
        chk(8'(ram_pointer), 8'h10);
        send_cmd(1'b1, 8'h41);
        chk(8'(ram_pointer), 8'h11);
        chk(dr, 8'h41);
        chk(ir, 8'h90);
        send_cmd(1'b0, 8'h04);
        send_cmd(1'b1, 8'h42);
        chk(8'(ram_pointer), 8'h10);
        par_read(1'b1);
        chk(par_rdata, 8'h42);
        chk(8'(ram_pointer), 8'h0f);
        chk(dr, CLEAR_CHAR);
        par_read(1'b0);
        chk(par_rdata, 8'h0f);
        send_cmd(1'b0, 8'h45);
        chk(8'(ram_sel), 8'(LHW_ICON));
        chk(8'(ram_pointer), 8'h05);
        send_cmd(1'b0, 8'h28);
        chk(8'(bus_width_select), 8'h00);
        send_cmd(1'b0, 8'h48);
        chk(8'(ram_sel), 8'(LHW_GLYPH));
        chk(8'(ram_pointer), 8'h08);
        send_cmd(1'b0, 8'h38);
        chk(8'(bus_width_select), 8'h01);
        send_cmd(1'b0, 8'h02);
        chk(8'(ram_pointer), 8'h00);
    endtask : t_ram_paths
    // The bench clock on the second link runs at 30 ns only inside frames.
    task automatic lk2_bit(input logic b, output logic rd);
        lk2.host_sda_oe = !b;
        #7.5 lk2.host_scl_oe = 1'b0;
        #7.5 rd = lk2.sda;
        #7.5 lk2.host_scl_oe = 1'b1;
        #7.5;
    endtask : lk2_bit
    task automatic lk2_byte(input logic [7:0] v, output logic ack);
        logic rd;
        for (int i = 7; i >= 0; i--) lk2_bit(v[i], rd);
        lk2_bit(1'b1, rd);
        ack = (rd === 1'b0);
    endtask : lk2_byte
    task automatic lk2_start();
        lk2.host_sda_oe = 1'b1;
        #7.5 lk2.host_scl_oe = 1'b1;
        #7.5;
    endtask : lk2_start
    task automatic lk2_stop();
        lk2.host_sda_oe = 1'b1;
        #7.5 lk2.host_scl_oe = 1'b0;
        #7.5 lk2.host_sda_oe = 1'b0;
        #15;
    endtask : lk2_stop
    task automatic t_link_faults();
        logic a;
        lk2_start();
        lk2_byte(8'h7e, a);
        chk(8'(a), 8'h00);
        lk2_byte(8'h80, a);
        lk2_byte(8'h85, a);
        chk(8'(a), 8'h00);
        lk2_stop();
        lk2_start();
        lk2_byte(8'h7d, a);
        chk(8'(a), 8'h00);
        lk2_byte(8'hff, a);
        lk2_stop();
        repeat (10) @(negedge sys_clk);
        chk(d2_ir, 8'h00);
        chk(8'(d2_ptr), 8'h00);
        lk2_start();
        for (int i = 0; i < 10; i++) begin
            lk2_byte(fr[i], a);
            chk(8'(a), 8'h01);
        end
        lk2_stop();
        repeat (10) @(negedge sys_clk);
        chk(d2_ir, 8'h06);
        chk(8'(d2_ptr), 8'h03);
        chk(d2_dr, 8'hc0);
        chk(8'(d2_busy), 8'h01);
    endtask : t_link_faults
    initial begin
        rst_b = 1'b0;
        volt5_sel = 1'b0;
        cmd_valid = 1'b0;
        cmd_rs = 1'b0;
        cmd_data = 8'h00;
        par_rd = 1'b0;
        par_rs = 1'b0;
        lk2.host_scl_o = 1'b0;
        lk2.host_sda_o = 1'b0;
        lk2.host_scl_oe = 1'b0;
        lk2.host_sda_oe = 1'b0;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        t_startup(1'b0);
        t_ram_paths();
        t_link_faults();
        t_startup(1'b1);
        stop_test();
    end
endmodule : lcd_host_write_interface_tb
